// *** hdl/dcts_channel.sv ***
`timescale 1ns/10ps
`default_nettype none
module dcts_channel
  import dcts_pkg::*;
#(
  parameter logic [15:0] RAM_TOP = 16'h47FF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [127:0] trigger_sources,
  input wire logic [DMA_CHANNELS-1:0] dma_channel_irq,
  input wire logic channel_busy,
  input wire logic session_done,
  input wire logic session_abort,
  input wire logic [15:0] transfer_counter,
  input wire logic [15:0] transfer_count_start,
  input wire logic counter_step,
  input wire dcts_access_t access,
  input wire logic dest_write_done,
  input wire logic dummy_write_done,
  output logic channel_trigger,
  output logic dummy_write_req,
  output logic channel_irq_pulse,
  output logic irq
);

  default clocking dcts_check_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [6:0] trigger_select;
  logic midpoint_interrupt_enable;
  logic channel_enable;
  logic dummy_write_mode;
  logic [15:0] upper_address_limit;
  logic [15:0] lower_address_limit;
  dcts_flags_t flags;
  logic buffered_write_pending;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable;
  logic enable_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic access_ph = psel & penable & ~pready;
  // Writes land on the completing edge, where the master sees pready
  wire logic wr_ok = psel & penable & pready & pwrite;
  wire logic hit_int = (paddr == ADDR_CH_INT);
  wire logic hit_ctrl = (paddr == ADDR_CTRL);
  wire logic hit_upper = (paddr == ADDR_UPPER);
  wire logic hit_lower = (paddr == ADDR_LOWER);
  wire logic hit_stat = (paddr == ADDR_EVT_STAT);
  wire logic hit_clr = (paddr == ADDR_EVT_CLR);
  wire logic hit_en = (paddr == ADDR_EVT_EN);
  wire logic mapped = hit_int | hit_ctrl | hit_upper | hit_lower |
                      hit_stat | hit_clr | hit_en;
  wire logic wr_int = wr_ok & hit_int;
  wire logic wr_ctrl = wr_ok & hit_ctrl;
  wire logic wr_upper = wr_ok & hit_upper;
  wire logic wr_lower = wr_ok & hit_lower;
  wire logic wr_clr = wr_ok & hit_clr;
  wire logic wr_en = wr_ok & hit_en;

  wire logic [15:0] int_view = {buffered_write_pending, trigger_select,
                                flags.high, flags.low, flags.done,
                                flags.half, flags.ovr, 2'b00,
                                midpoint_interrupt_enable};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_int) begin
      rd_mux = {16'h0000, int_view};
    end else if (hit_ctrl) begin
      rd_mux = {30'h0000_0000, dummy_write_mode, channel_enable};
    end else if (hit_upper) begin
      rd_mux = {16'h0000, upper_address_limit};
    end else if (hit_lower) begin
      rd_mux = {16'h0000, lower_address_limit};
    end else if (hit_stat) begin
      rd_mux = {28'h000_0000, evt_status};
    end else if (hit_en) begin
      rd_mux = {28'h000_0000, evt_enable};
    end
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access_ph;
      pslverr <= access_ph & ~mapped;
      if (access_ph && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger selection and overrun
  // ----------------------------------------------------------------
  logic trig_raw;
  dcts_trig_sel u_trig_sel (
    .pclk(pclk),
    .presetn(presetn),
    .trigger_sources(trigger_sources),
    .dma_channel_irq(dma_channel_irq),
    .trigger_select(trigger_select),
    .trigger_pulse(trig_raw)
  );

  // A trigger during a disabled channel is dropped, not queued.
  wire logic trig_live = trig_raw & channel_enable;
  wire logic ev_ovr = trig_live & channel_busy;

  // ----------------------------------------------------------------
  // Limit checks on attempted accesses only
  // ----------------------------------------------------------------
  // No look-ahead on pointers: a check needs the access strobe.
  wire logic ev_high = access.valid &
                       ((access.addr > upper_address_limit) |
                        (access.addr > RAM_TOP));
  wire logic ev_low = access.valid &
                      (access.addr < lower_address_limit) &
                      (access.addr > SFR_END);

  // ----------------------------------------------------------------
  // Session and midpoint
  // ----------------------------------------------------------------
  wire logic session_start = channel_enable & ~enable_q;
  wire logic ev_done = session_done & channel_enable;
  wire logic [15:0] half_count = {1'b0, transfer_count_start[15:1]};
  wire logic ev_half = counter_step & channel_enable &
                       (transfer_counter == half_count);

  // ----------------------------------------------------------------
  // Channel interrupt register
  // ----------------------------------------------------------------
  // Hardware set wins over a software write in the same cycle.
  dcts_flags_t next_flags;
  always_comb begin
    next_flags = flags;
    if (wr_int) begin
      next_flags.high = pwdata[BIT_HIGH];
      next_flags.low = pwdata[BIT_LOW];
      next_flags.done = pwdata[BIT_DONE];
      next_flags.half = pwdata[BIT_HALF];
      next_flags.ovr = pwdata[BIT_OVR];
    end
    if (session_start || session_abort) begin
      next_flags.done = 1'b0;
    end
    if (ev_high) begin
      next_flags.high = 1'b1;
    end
    if (ev_low) begin
      next_flags.low = 1'b1;
    end
    if (ev_done) begin
      next_flags.done = 1'b1;
    end
    if (ev_half) begin
      next_flags.half = 1'b1;
    end
    if (ev_ovr) begin
      next_flags.ovr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
      trigger_select <= TRIG_OFF;
      midpoint_interrupt_enable <= 1'b0;
    end else begin
      flags <= next_flags;
      if (wr_int) begin
        trigger_select <= pwdata[SEL_MSB:SEL_LSB];
        midpoint_interrupt_enable <= pwdata[BIT_HALF_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and limit registers
  // ----------------------------------------------------------------
  // Limits are trusted as written before enable; no sanity check.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable <= 1'b0;
      dummy_write_mode <= 1'b0;
      upper_address_limit <= UPPER_RST;
      lower_address_limit <= LOWER_RST;
      enable_q <= 1'b0;
    end else begin
      enable_q <= channel_enable;
      if (wr_ctrl) begin
        channel_enable <= pwdata[BIT_CH_EN];
        dummy_write_mode <= pwdata[BIT_DUMMY];
      end
      if (wr_upper) begin
        upper_address_limit <= pwdata[15:0];
      end
      if (wr_lower) begin
        lower_address_limit <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Null write mode
  // ----------------------------------------------------------------
  wire logic dummy_needed = dest_write_done & dummy_write_mode;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dummy_write_req <= 1'b0;
      buffered_write_pending <= 1'b0;
    end else begin
      dummy_write_req <= dummy_needed;
      if (dummy_needed) begin
        buffered_write_pending <= 1'b1;
      end else if (dummy_write_done) begin
        buffered_write_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and event status
  // ----------------------------------------------------------------
  // Only hardware events feed these, so software writes to the flag
  // bits above can never produce a request.
  wire logic irq_event = ev_done |
                         (ev_half & midpoint_interrupt_enable);
  wire logic [EVT_W-1:0] evt_hit = {ev_high | ev_low, ev_ovr, ev_half,
                                    ev_done};
  wire logic [EVT_W-1:0] evt_clr = wr_clr ? pwdata[EVT_W-1:0] : '0;
  wire logic [EVT_W-1:0] next_evt = (evt_status & ~evt_clr) | evt_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_irq_pulse <= 1'b0;
      channel_trigger <= 1'b0;
      evt_status <= '0;
      evt_enable <= '0;
      irq <= 1'b0;
    end else begin
      channel_irq_pulse <= irq_event;
      channel_trigger <= trig_live;
      evt_status <= next_evt;
      if (wr_en) begin
        evt_enable <= pwdata[EVT_W-1:0];
      end
      irq <= |(next_evt & (wr_en ? pwdata[EVT_W-1:0] : evt_enable));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pending_tracks_a: assert property (
    dest_write_done && dummy_write_mode |=> buffered_write_pending)
    else $error("pending flag not set after destination write");

  select_write_a: assert property (
    wr_int |=> trigger_select == $past(pwdata[SEL_MSB:SEL_LSB]))
    else $error("trigger select not taken from write");

  high_limit_a: assert property (
    access.valid && (access.addr > upper_address_limit ||
    access.addr > RAM_TOP) |=> flags.high)
    else $error("high limit access not flagged");

  low_limit_a: assert property (
    access.valid && access.addr < lower_address_limit &&
    access.addr > SFR_END |=> flags.low)
    else $error("low limit access not flagged");

  no_access_check_a: assert property (
    !access.valid && !wr_int && !flags.high |=> !flags.high)
    else $error("limit flag set without an access");

  done_flag_a: assert property (
    session_done && channel_enable |=> flags.done)
    else $error("completion not flagged");

  session_clear_a: assert property (
    $rose(channel_enable) && !session_done |=> !flags.done)
    else $error("completion flag survives new session");

  half_flag_a: assert property (
    ev_half |=> flags.half)
    else $error("midpoint not flagged");

  overrun_flag_a: assert property (
    trig_raw && channel_enable && channel_busy |=> flags.ovr)
    else $error("overrun not flagged");

  half_irq_a: assert property (
    ev_half && !ev_done |=>
    channel_irq_pulse == $past(midpoint_interrupt_enable))
    else $error("midpoint interrupt does not follow enable");

  sw_set_quiet_a: assert property (
    wr_int && !ev_done && !ev_half |=> !channel_irq_pulse)
    else $error("software flag write raised a request");

  dummy_follow_a: assert property (
    dummy_write_req |-> $past(dest_write_done) && $past(dummy_write_mode))
    else $error("dummy write without destination write");

  flag_sticky_a: assert property (
    flags.ovr && !wr_int |=> flags.ovr)
    else $error("overrun flag dropped without software");

  pulse_single_a: assert property (
    channel_irq_pulse && !irq_event |=> !channel_irq_pulse)
    else $error("interrupt request longer than one cycle");

endmodule : dcts_channel
`default_nettype wire

// *** hdl/dcts_pkg.sv ***
package dcts_pkg;

  // ----------------------------------------------------------------
  // Bus map
  // ----------------------------------------------------------------
  localparam int unsigned PADDR_W = 8;
  localparam logic [7:0] ADDR_CH_INT = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_UPPER = 8'h08;
  localparam logic [7:0] ADDR_LOWER = 8'h0C;
  localparam logic [7:0] ADDR_EVT_STAT = 8'h10;
  localparam logic [7:0] ADDR_EVT_CLR = 8'h14;
  localparam logic [7:0] ADDR_EVT_EN = 8'h18;

  // ----------------------------------------------------------------
  // Channel interrupt and control register fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_PENDING = 15;
  localparam int unsigned SEL_MSB = 14;
  localparam int unsigned SEL_LSB = 8;
  localparam int unsigned BIT_HIGH = 7;
  localparam int unsigned BIT_LOW = 6;
  localparam int unsigned BIT_DONE = 5;
  localparam int unsigned BIT_HALF = 4;
  localparam int unsigned BIT_OVR = 3;
  localparam int unsigned BIT_HALF_EN = 0;
  localparam int unsigned BIT_CH_EN = 0;
  localparam int unsigned BIT_DUMMY = 1;

  // Event status / clear / enable layout
  localparam int unsigned EVT_DONE = 0;
  localparam int unsigned EVT_HALF = 1;
  localparam int unsigned EVT_OVR = 2;
  localparam int unsigned EVT_LIMIT = 3;
  localparam int unsigned EVT_W = 4;

  localparam logic [15:0] SFR_END = 16'h07FF;
  localparam logic [15:0] UPPER_RST = 16'hFFFF;
  localparam logic [15:0] LOWER_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Trigger codes
  // ----------------------------------------------------------------
  localparam logic [6:0] TRIG_OFF = 7'h00;
  localparam logic [6:0] TRIG_DMA_CH0 = 7'h50;
  localparam logic [6:0] TRIG_DMA_CH5 = 7'h4B;
  localparam logic [6:0] TRIG_UART2_TX = 7'h41;
  localparam logic [6:0] TRIG_UART1_ERR = 7'h46;
  localparam logic [6:0] TRIG_SPI3_RX = 7'h20;
  localparam logic [6:0] TRIG_SPI1_GEN = 7'h28;
  localparam logic [6:0] TRIG_I2C2_SLV = 7'h2F;
  localparam logic [6:0] TRIG_I2C1_COL = 7'h34;
  localparam logic [6:0] TRIG_PIN_CHG = 7'h6D;
  localparam logic [6:0] TRIG_EXT0 = 7'h6C;
  localparam logic [6:0] TRIG_EXT4 = 7'h68;
  localparam int unsigned DMA_CHANNELS = 6;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } dcts_access_t;

  typedef struct packed {
    logic high;
    logic low;
    logic done;
    logic half;
    logic ovr;
  } dcts_flags_t;

endpackage : dcts_pkg

// *** hdl/dcts_trig_sel.sv ***
`timescale 1ns/10ps
`default_nettype none
module dcts_trig_sel
  import dcts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [127:0] trigger_sources,
  input wire logic [DMA_CHANNELS-1:0] dma_channel_irq,
  input wire logic [6:0] trigger_select,
  output logic trigger_pulse
);

  // ----------------------------------------------------------------
  // Source map
  // ----------------------------------------------------------------
  // Codes of other channels' completion replace the plain source lines,
  // so channels chain without extra wiring at the top.
  logic [127:0] merged;
  genvar g;
  generate
    for (g = 0; g < 128; g++) begin : g_src
      if (g <= int'(TRIG_DMA_CH0) && g >= int'(TRIG_DMA_CH5)) begin : g_dma
        assign merged[g] = dma_channel_irq[int'(TRIG_DMA_CH0) - g];
      end else begin : g_pin
        assign merged[g] = trigger_sources[g];
      end
    end
  endgenerate

  wire logic selected = (trigger_select != TRIG_OFF) &
                        merged[trigger_select];
  logic selected_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selected_q <= 1'b0;
      trigger_pulse <= 1'b0;
    end else begin
      selected_q <= selected;
      trigger_pulse <= selected & ~selected_q;
    end
  end

  off_no_trigger_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(trigger_select) == TRIG_OFF |-> !trigger_pulse)
    else $error("trigger fired while selection is off");

endmodule : dcts_trig_sel
`default_nettype wire

// *** hdl/dcts_unused_placeholder.sv ***
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** tb/dcts_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
module dcts_peer
  import dcts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic channel_trigger,
  input wire logic dummy_write_req,
  output logic [127:0] trigger_sources,
  output logic [DMA_CHANNELS-1:0] dma_channel_irq,
  output logic channel_busy,
  output logic dummy_write_done
);
  // ----------------------------------------------------------------
  // Engine and peripheral lines
  // ----------------------------------------------------------------
  // Latency in cycles; raised by the bench to force overlapping work
  int lat = 1;
  int busy_cnt = 0;
  int dw_cnt = 0;

  initial begin
    trigger_sources = '0;
    dma_channel_irq = '0;
  end

  // Source lines are levels; each event is one high cycle
  task automatic fire(input logic [6:0] code);
    @(posedge pclk);
    if (code >= TRIG_DMA_CH5 && code <= TRIG_DMA_CH0) begin
      dma_channel_irq[TRIG_DMA_CH0 - code] <= 1'b1;
    end else begin
      trigger_sources[code] <= 1'b1;
    end
    @(posedge pclk);
    trigger_sources <= '0;
    dma_channel_irq <= '0;
  endtask : fire

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 0;
      dw_cnt <= 0;
    end else begin
      if (channel_trigger === 1'b1) busy_cnt <= lat;
      else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      if (dummy_write_req === 1'b1) dw_cnt <= lat;
      else if (dw_cnt > 0) dw_cnt <= dw_cnt - 1;
    end
  end

  assign channel_busy = (busy_cnt > 0);
  assign dummy_write_done = (dw_cnt == 1);
endmodule : dcts_peer
`default_nettype wire

// *** tb/dcts_channel_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dcts_channel_bench
  import dcts_pkg::*;
;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [127:0] trigger_sources;
  logic [DMA_CHANNELS-1:0] dma_channel_irq;
  logic channel_busy;
  logic dummy_write_done;
  logic session_done = 1'b0;
  logic session_abort = 1'b0;
  logic counter_step = 1'b0;
  logic dest_write_done = 1'b0;
  logic [15:0] transfer_counter = 16'h0000;
  logic [15:0] transfer_count_start = 16'h0010;
  dcts_access_t access = '0;
  logic channel_trigger;
  logic dummy_write_req;
  logic channel_irq_pulse;
  logic irq;
  logic [31:0] lfsr = 32'hAE64C135;
  logic [32:0] exp_q[$];
  logic [32:0] got;
  logic [6:0] lo [5] = '{7'h41, 7'h4B, 7'h20, 7'h2F, 7'h68};
  logic [6:0] hi [5] = '{7'h46, 7'h50, 7'h28, 7'h34, 7'h6D};
  int num_errors = 0;
  int checks = 0;
  int trig_n = 0;
  int pulse_n = 0;
  int dwr_n = 0;
  int n;

  dcts_channel u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .trigger_sources,
    .dma_channel_irq, .channel_busy, .session_done, .session_abort,
    .transfer_counter, .transfer_count_start, .counter_step, .access,
    .dest_write_done, .dummy_write_done, .channel_trigger,
    .dummy_write_req, .channel_irq_pulse, .irq);

  dcts_peer u_peer (.pclk, .presetn, .channel_trigger, .dummy_write_req,
    .trigger_sources, .dma_channel_irq, .channel_busy, .dummy_write_done);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (channel_trigger === 1'b1) trig_n++;
    if (channel_irq_pulse === 1'b1) pulse_n++;
    if (dummy_write_req === 1'b1) dwr_n++;
    if (psel && penable && pready === 1'b1) begin
      got = exp_q.pop_front();
      if (pwrite) `CHK(pslverr, got[32])
      else `CHK({pslverr, prdata}, got)
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_step

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  // Kinds: 0 done, 1 abort, 2 step, 3 dest write, 4 access, 5 idle addr
  task automatic pulse(input int s, input logic [15:0] v);
    transfer_counter <= v;
    session_done <= (s == 0);
    session_abort <= (s == 1);
    counter_step <= (s == 2);
    dest_write_done <= (s == 3);
    access <= '{valid: (s == 4), addr: v};
    @(posedge pclk);
    {session_done, session_abort, counter_step, dest_write_done} <= 4'h0;
    access <= '0;
    tick(3);
  endtask : pulse

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    tick(8000);
    num_errors++;
    end_of_test();
  end

  initial begin
    tick(6);
    presetn <= 1'b1;
    tick(1);
    rd(ADDR_CH_INT, 32'h0);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_UPPER, 32'hFFFF);
    rd(ADDR_LOWER, 32'h0);
    rd(ADDR_EVT_STAT, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, 33'h1_0000_0000);
    apb(1'b1, 8'h1C, 32'hFFFF, 33'h1_0000_0000);
    wr(ADDR_EVT_EN, 32'hF);
    repeat (4) begin
      lfsr = lfsr_step(lfsr);
      wr(ADDR_CH_INT, lfsr);
      rd(ADDR_CH_INT, lfsr & 32'h7FF9);
    end
    `CHK(irq, 1'b0);
    `CHK(pulse_n, 0);
    wr(ADDR_CH_INT, 32'h0);
    rd(ADDR_CH_INT, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    n = trig_n;
    u_peer.fire(TRIG_OFF);
    tick(4);
    `CHK(trig_n, n);
    for (int i = 0; i < 5; i++) begin
      for (int c = lo[i]; c <= hi[i]; c++) begin
        wr(ADDR_CH_INT, {17'h0, 7'(c), 8'h00});
        n = trig_n;
        u_peer.fire(7'(c));
        tick(4);
        `CHK(trig_n, n + 1);
      end
    end
    u_peer.lat = 20;
    u_peer.fire(TRIG_PIN_CHG);
    tick(6);
    u_peer.fire(TRIG_PIN_CHG);
    tick(4);
    rd(ADDR_CH_INT, 32'h6D08);
    rd(ADDR_EVT_STAT, 32'h4);
    `CHK(irq, 1'b1);
    wr(ADDR_EVT_CLR, 32'hF);
    rd(ADDR_EVT_STAT, 32'h0);
    `CHK(irq, 1'b0);
    u_peer.lat = 1;
    wr(ADDR_CH_INT, 32'h0);
    pulse(2, 16'h0009);
    pulse(2, 16'h0008);
    rd(ADDR_CH_INT, 32'h10);
    `CHK(pulse_n, 0);
    pulse(0, 16'h0);
    rd(ADDR_CH_INT, 32'h30);
    `CHK(pulse_n, 1);
    rd(ADDR_EVT_STAT, 32'h3);
    wr(ADDR_CH_INT, 32'h1);
    pulse(2, 16'h0008);
    `CHK(pulse_n, 2);
    pulse(0, 16'h0);
    `CHK(pulse_n, 3);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_CH_INT, 32'h31);
    pulse(0, 16'h0);
    `CHK(pulse_n, 3);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_CH_INT, 32'h11);
    pulse(0, 16'h0);
    pulse(1, 16'h0);
    rd(ADDR_CH_INT, 32'h11);
    wr(ADDR_EVT_CLR, 32'hF);
    wr(ADDR_EVT_EN, 32'h2);
    pulse(0, 16'h0);
    rd(ADDR_EVT_STAT, 32'h1);
    `CHK(irq, 1'b0);
    wr(ADDR_EVT_EN, 32'hF);
    tick(2);
    `CHK(irq, 1'b1);
    wr(ADDR_EVT_CLR, 32'h1);
    tick(2);
    `CHK(irq, 1'b0);
    wr(ADDR_CH_INT, 32'h0);
    wr(ADDR_UPPER, 32'h1000);
    wr(ADDR_LOWER, 32'h0900);
    pulse(5, 16'hF000);
    pulse(4, 16'h1000);
    pulse(4, 16'h0900);
    pulse(4, 16'h07FF);
    rd(ADDR_CH_INT, 32'h0);
    pulse(4, 16'h1001);
    rd(ADDR_CH_INT, 32'h80);
    rd(ADDR_EVT_STAT, 32'h8);
    pulse(4, 16'h08FF);
    rd(ADDR_CH_INT, 32'hC0);
    wr(ADDR_CH_INT, 32'h0);
    wr(ADDR_UPPER, 32'hFFFF);
    pulse(4, 16'h47FF);
    pulse(4, 16'h4800);
    rd(ADDR_CH_INT, 32'h80);
    u_peer.lat = 20;
    n = dwr_n;
    pulse(3, 16'h0);
    `CHK(dwr_n, n);
    wr(ADDR_CTRL, 32'h3);
    pulse(3, 16'h0);
    `CHK(dwr_n, n + 1);
    rd(ADDR_CH_INT, 32'h8080);
    tick(20);
    rd(ADDR_CH_INT, 32'h80);
    tick(4);
    end_of_test();
  end
endmodule : dcts_channel_bench
`default_nettype wire
